// ===== uce_params.svh
// Constants for the serial character engine.
// Overview of operation
// [R1] Receiver starts disabled, enabled by command.
// [R2] Transmitter starts disabled, enabled by command.
// [R3] Directions enable together or independently.
// [R4] Soft reset stops direction, clears flags.
// [R5] Receive disable finishes current character first.
// [R6] Transmit disable drains shifter and holding register.
// [R7] Frame: start, data, parity, stop bits.
// [R8] Nine-bit select overrides character length field.
// [R9] Bit order selects MSB or LSB first.
// [R10] One-and-half stop only in asynchronous mode.
// [R11] Holding moves to shifter; flags show emptiness.
// [R12] Flags low when disabled; busy writes dropped.
// [R13] Oversample 16x, or 8x when halved.
// [R14] Start at half-bit lows; bits every period.
// [R15] Receiver uses one stop, then hunts; code samples two stops in synchronous two-stop mode.
// [R16] Synchronous receive samples on rising clock.
// [R17] Completed character loads holding; overrun flagged.
// [R18] Clear-status command clears overrun flag.
// [R19] Even parity: ones count plus bit even.
// [R20] Odd parity: ones count plus bit odd.
// [R21] Mark sends one, space zero, none nothing.
// [R22] Parity mismatch sets error; clear-status clears.
// [R23] Disable beats enable in one command.
`ifndef UCE_PARAMS_SVH
`define UCE_PARAMS_SVH
`define UCE_OS_FULL 5'h10
`define UCE_OS_HALF 5'h08
`define UCE_HB_FULL 5'h08
`define UCE_HB_HALF 5'h04
`define UCE_CHR_BASE 4'h5
`define UCE_NINE_BITS 4'h9
`define UCE_ALL_DATA 9'h1ff
`define UCE_STOP_ONE_HALF 2'h1
`define UCE_STOP_TWO 2'h2
`define UCE_HALVES_ONE 3'h2
`define UCE_HALVES_ONE_HALF 3'h3
`define UCE_HALVES_TWO 3'h4
`define UCE_HALVES_BIT 3'h1
`define UCE_PAR_EVEN 3'h0
`define UCE_PAR_ODD 3'h1
`define UCE_PAR_SPACE 3'h2
`define UCE_PAR_MARK 3'h3
`define UCE_LINE_IDLE 1'h1
`define UCE_LINE_START 1'h0
`endif

// ===== uce_pkg.sv
// Types shared by the serial character engine.
package uce_pkg;
    typedef struct packed {
        logic rx_enable;
        logic rx_disable;
        logic rx_soft_reset;
        logic tx_enable;
        logic tx_disable;
        logic tx_soft_reset;
        logic clear_status;
    } uce_cmd_t;
    typedef struct packed {
        logic [1:0] char_length;
        logic nine_bit;
        logic [2:0] check_bit_mode;
        logic bit_order;
        logic [1:0] stop_count;
        logic sync_mode;
        logic sample_halving;
    } uce_mode_t;
    typedef struct packed {
        logic tx_holding_free;
        logic tx_all_done;
        logic rx_char_available;
        logic rx_overrun;
        logic check_bit_error;
        logic rx_enabled;
        logic tx_enabled;
    } uce_status_t;
    typedef enum logic [2:0] {UCE_TX_IDLE, UCE_TX_START, UCE_TX_DATA,
        UCE_TX_PARITY, UCE_TX_STOP} uce_tx_state_t;
    typedef enum logic [1:0] {UCE_RX_IDLE, UCE_RX_DATA, UCE_RX_PARITY,
        UCE_RX_STOP} uce_rx_state_t;
endpackage : uce_pkg

// ===== uce_char_engine.sv
// Character engine: command, holding registers, transmit and receive.
`timescale 1ns/100ps
`include "uce_params.svh"
module uce_char_engine (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic cmd_write_in,
    input wire uce_pkg::uce_cmd_t cmd_in,
    input wire logic mode_write_in,
    input wire uce_pkg::uce_mode_t mode_in,
    input wire logic tx_write_in,
    input wire logic [8:0] tx_data_in,
    input wire logic rx_read_in,
    input wire logic sample_tick_in,
    input wire logic serial_clock_in,
    input wire logic rx_line_in,
    output logic tx_line_out,
    output logic [8:0] rx_data_out,
    output uce_pkg::uce_status_t status_out
);
    function automatic logic par_bit(input logic [2:0] m, input logic odd);
        case (m)
            `UCE_PAR_EVEN: par_bit = odd;
            `UCE_PAR_ODD: par_bit = ~odd;
            `UCE_PAR_MARK: par_bit = 1'h1;
            default: par_bit = 1'h0;
        endcase
    endfunction : par_bit

    uce_pkg::uce_mode_t mode_q;
    uce_pkg::uce_tx_state_t tx_st_q;
    uce_pkg::uce_rx_state_t rx_st_q;
    logic [1:0] rxd_sync_q;
    logic [1:0] sclk_sync_q;
    logic sclk_prev_q;
    logic tx_en_q, tx_dis_pend_q, rx_en_q, rx_dis_pend_q;
    logic [8:0] thr_q, tx_sh_q, rx_buf_q, rhr_q;
    logic thr_full_q, tx_par_q, tx_line_q, rx_par_q;
    logic [4:0] tx_div_q, rx_cnt_q;
    logic [2:0] tx_half_q;
    logic [3:0] tx_idx_q, rx_idx_q;
    logic rx_char_available_flag_q, rx_overrun_flag_q, check_bit_error_flag_q;
    uce_pkg::uce_status_t status_q;

    uce_pkg::uce_cmd_t cmd;
    assign cmd = cmd_write_in ? cmd_in : '0;

    // [R8] nine-bit override
    wire [3:0] data_bits = mode_q.nine_bit ? `UCE_NINE_BITS
        : `UCE_CHR_BASE + {2'h0, mode_q.char_length};
    wire [3:0] last_idx = data_bits - 4'h1;
    wire [8:0] data_mask = `UCE_ALL_DATA >> (`UCE_NINE_BITS - data_bits);
    // [R21] parity absent when none
    wire par_on = mode_q.check_bit_mode <= `UCE_PAR_MARK;
    wire sync = mode_q.sync_mode;
    // [R13] oversampling ratio
    wire [4:0] os_len = mode_q.sample_halving ? `UCE_OS_HALF : `UCE_OS_FULL;
    wire [4:0] hb_len = mode_q.sample_halving ? `UCE_HB_HALF : `UCE_HB_FULL;
    // [R10] half stop bit only asynchronous
    wire [2:0] stop_halves = (mode_q.stop_count == `UCE_STOP_TWO)
        ? `UCE_HALVES_TWO
        : (mode_q.stop_count == `UCE_STOP_ONE_HALF && !sync)
        ? `UCE_HALVES_ONE_HALF : `UCE_HALVES_ONE;

    wire rxd = rxd_sync_q[1];
    wire sclk = sclk_sync_q[1];
    wire sclk_rise = sclk & ~sclk_prev_q;
    wire sclk_fall = ~sclk & sclk_prev_q;

    // Transmit timing runs in half bits so that a 1.5 stop fits.
    wire half_tick = sync ? (sclk_rise | sclk_fall)
        : (sample_tick_in && tx_div_q == hb_len - 5'h1);
    // [R7] bits change on falling serial clock edges
    wire start_ok = sync ? sclk_fall : half_tick;
    wire tx_busy = tx_st_q != uce_pkg::UCE_TX_IDLE;
    wire [2:0] ph_last = (tx_st_q == uce_pkg::UCE_TX_STOP) ? stop_halves - 3'h1
        : `UCE_HALVES_BIT;
    wire ph_end = tx_busy && half_tick && tx_half_q == ph_last;
    // [R11] holding register feeds shifter back to back
    wire tx_load = tx_en_q && thr_full_q
        && ((!tx_busy && start_ok)
        || (tx_st_q == uce_pkg::UCE_TX_STOP && ph_end));
    // [R12] writes only land in a free holding register
    wire tx_free = tx_en_q && !thr_full_q;
    wire tx_take = tx_write_in && tx_free;
    // [R9] bit order selection
    wire [3:0] tx_pos = mode_q.bit_order ? last_idx - tx_idx_q : tx_idx_q;
    wire [3:0] rx_pos = mode_q.bit_order ? last_idx - rx_idx_q : rx_idx_q;
    // [R19] [R20] parity over active data bits
    wire thr_par = par_bit(mode_q.check_bit_mode, ^(thr_q & data_mask));
    wire rx_exp_par = par_bit(mode_q.check_bit_mode, ^(rx_buf_q & data_mask));

    logic tx_line_now;
    always_comb
    begin
        case (tx_st_q)
            uce_pkg::UCE_TX_START: tx_line_now = `UCE_LINE_START;
            uce_pkg::UCE_TX_DATA: tx_line_now = tx_sh_q[tx_pos];
            uce_pkg::UCE_TX_PARITY: tx_line_now = tx_par_q;
            default: tx_line_now = `UCE_LINE_IDLE;
        endcase
    end

    wire rx_idle = rx_st_q == uce_pkg::UCE_RX_IDLE;
    // [R14] start after half a bit of low samples
    wire rx_start_async = !sync && sample_tick_in && rx_idle && rx_en_q
        && !rxd && rx_cnt_q == hb_len - 5'h1;
    // [R16] synchronous start on a low rising-edge sample
    wire rx_start_sync = sync && sclk_rise && rx_idle && rx_en_q && !rxd;
    wire rx_start = rx_start_async || rx_start_sync;
    wire rx_sample = !rx_idle && (sync ? sclk_rise
        : (sample_tick_in && rx_cnt_q == os_len - 5'h1));
    // [R15] asynchronous receive ends on the first stop bit
    wire rx_more_stop = sync && mode_q.stop_count == `UCE_STOP_TWO
        && rx_idx_q == 4'h0;
    wire rx_done = rx_sample && rx_st_q == uce_pkg::UCE_RX_STOP
        && !rx_more_stop;
    // [R17] overrun when unread character is replaced
    wire rx_overrun_flag_set = rx_done && rx_char_available_flag_q && !rx_read_in;
    // [R22] mismatching check bit
    wire check_bit_error_flag_set = rx_done && par_on && rx_par_q != rx_exp_par;

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rxd_sync_q <= 2'h3;
            sclk_sync_q <= 2'h0;
            sclk_prev_q <= 1'h0;
            mode_q <= '0;
        end
        else
        begin
            rxd_sync_q <= {rxd_sync_q[0], rx_line_in};
            sclk_sync_q <= {sclk_sync_q[0], serial_clock_in};
            sclk_prev_q <= sclk;
            // [R1] configuration accepted while disabled
            if (mode_write_in)
                mode_q <= mode_in;
        end
    end

    // [R2] [R3] transmit enable, independent of receive
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_en_q <= 1'h0;
            tx_dis_pend_q <= 1'h0;
        end
        // [R23] disable wins over enable
        else if (cmd.tx_disable)
            tx_dis_pend_q <= tx_en_q;
        else if (cmd.tx_enable)
        begin
            tx_en_q <= 1'h1;
            tx_dis_pend_q <= 1'h0;
        end
        // [R6] stop only once both characters are out
        else if (tx_dis_pend_q && !tx_busy && !thr_full_q)
        begin
            tx_en_q <= 1'h0;
            tx_dis_pend_q <= 1'h0;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_st_q <= uce_pkg::UCE_TX_IDLE;
            thr_q <= 9'h000;
            thr_full_q <= 1'h0;
            tx_sh_q <= 9'h000;
            tx_par_q <= 1'h0;
            tx_div_q <= 5'h00;
            tx_half_q <= 3'h0;
            tx_idx_q <= 4'h0;
        end
        // [R4] transmit soft reset keeps configuration
        else if (cmd.tx_soft_reset)
        begin
            tx_st_q <= uce_pkg::UCE_TX_IDLE;
            thr_full_q <= 1'h0;
            tx_div_q <= 5'h00;
            tx_half_q <= 3'h0;
            tx_idx_q <= 4'h0;
        end
        else
        begin
            if (sample_tick_in)
                tx_div_q <= (tx_div_q == hb_len - 5'h1) ? 5'h00
                    : tx_div_q + 5'h01;
            if (tx_take)
            begin
                thr_q <= tx_data_in;
                thr_full_q <= 1'h1;
            end
            if (tx_load)
            begin
                tx_sh_q <= thr_q;
                tx_par_q <= thr_par;
                thr_full_q <= 1'h0;
                tx_st_q <= uce_pkg::UCE_TX_START;
                tx_half_q <= 3'h0;
                tx_idx_q <= 4'h0;
            end
            else if (ph_end)
            begin
                tx_half_q <= 3'h0;
                case (tx_st_q)
                    uce_pkg::UCE_TX_START: tx_st_q <= uce_pkg::UCE_TX_DATA;
                    uce_pkg::UCE_TX_DATA:
                    begin
                        tx_idx_q <= tx_idx_q + 4'h1;
                        if (tx_idx_q == last_idx)
                            tx_st_q <= par_on ? uce_pkg::UCE_TX_PARITY
                                : uce_pkg::UCE_TX_STOP;
                    end
                    uce_pkg::UCE_TX_PARITY: tx_st_q <= uce_pkg::UCE_TX_STOP;
                    default: tx_st_q <= uce_pkg::UCE_TX_IDLE;
                endcase
            end
            else if (tx_busy && half_tick)
                tx_half_q <= tx_half_q + 3'h1;
        end
    end

    // [R1] [R3] receive enable, independent of transmit
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_en_q <= 1'h0;
            rx_dis_pend_q <= 1'h0;
        end
        // [R23] disable wins over enable
        else if (cmd.rx_disable)
            rx_dis_pend_q <= rx_en_q;
        else if (cmd.rx_enable)
        begin
            rx_en_q <= 1'h1;
            rx_dis_pend_q <= 1'h0;
        end
        // [R5] finish the character in progress
        else if (rx_dis_pend_q && (rx_idle || cmd.rx_soft_reset))
        begin
            rx_en_q <= 1'h0;
            rx_dis_pend_q <= 1'h0;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_st_q <= uce_pkg::UCE_RX_IDLE;
            rx_cnt_q <= 5'h00;
            rx_idx_q <= 4'h0;
            rx_buf_q <= 9'h000;
            rx_par_q <= 1'h0;
            rhr_q <= 9'h000;
        end
        // [R4] receive soft reset keeps configuration
        else if (cmd.rx_soft_reset)
        begin
            rx_st_q <= uce_pkg::UCE_RX_IDLE;
            rx_cnt_q <= 5'h00;
            rx_idx_q <= 4'h0;
        end
        else if (rx_start)
        begin
            rx_st_q <= uce_pkg::UCE_RX_DATA;
            rx_cnt_q <= 5'h00;
            rx_idx_q <= 4'h0;
            rx_buf_q <= 9'h000;
        end
        else if (rx_idle)
        begin
            if (sample_tick_in)
                rx_cnt_q <= rxd ? 5'h00 : rx_cnt_q + 5'h01;
        end
        else if (rx_sample)
        begin
            rx_cnt_q <= 5'h00;
            case (rx_st_q)
                uce_pkg::UCE_RX_DATA:
                begin
                    rx_buf_q[rx_pos] <= rxd;
                    rx_idx_q <= rx_idx_q + 4'h1;
                    if (rx_idx_q == last_idx)
                    begin
                        rx_idx_q <= 4'h0;
                        rx_st_q <= par_on ? uce_pkg::UCE_RX_PARITY
                            : uce_pkg::UCE_RX_STOP;
                    end
                end
                uce_pkg::UCE_RX_PARITY:
                begin
                    rx_par_q <= rxd;
                    rx_st_q <= uce_pkg::UCE_RX_STOP;
                end
                default:
                begin
                    rx_idx_q <= 4'h1;
                    // [R17] completed character replaces holding data
                    if (rx_done)
                    begin
                        rhr_q <= rx_buf_q & data_mask;
                        rx_st_q <= uce_pkg::UCE_RX_IDLE;
                    end
                end
            endcase
        end
        else if (sample_tick_in)
            rx_cnt_q <= rx_cnt_q + 5'h01;
    end

    // Flags: a setting event wins over a read or clear-status in the same cycle; receive soft reset wins over both.
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_char_available_flag_q <= 1'h0;
            rx_overrun_flag_q <= 1'h0;
            check_bit_error_flag_q <= 1'h0;
        end
        else if (cmd.rx_soft_reset)
        begin
            rx_char_available_flag_q <= 1'h0;
            rx_overrun_flag_q <= 1'h0;
            check_bit_error_flag_q <= 1'h0;
        end
        else
        begin
            rx_char_available_flag_q <= rx_done || (rx_char_available_flag_q && !rx_read_in);
            // [R18] clear-status clears overrun
            rx_overrun_flag_q <= rx_overrun_flag_set || (rx_overrun_flag_q && !cmd.clear_status);
            // [R22] clear-status clears parity error
            check_bit_error_flag_q <= check_bit_error_flag_set || (check_bit_error_flag_q && !cmd.clear_status);
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_line_q <= `UCE_LINE_IDLE;
            status_q <= '0;
        end
        else
        begin
            tx_line_q <= tx_line_now;
            // [R11] [R12] transmit flags, low while disabled
            status_q.tx_holding_free <= tx_free;
            status_q.tx_all_done <= tx_free && !tx_busy;
            status_q.rx_char_available <= rx_char_available_flag_q;
            status_q.rx_overrun <= rx_overrun_flag_q;
            status_q.check_bit_error <= check_bit_error_flag_q;
            status_q.rx_enabled <= rx_en_q;
            status_q.tx_enabled <= tx_en_q;
        end
    end

    assign tx_line_out = tx_line_q;
    assign rx_data_out = rhr_q;
    assign status_out = status_q;
endmodule : uce_char_engine

// ===== uce_char_engine_monitor.sv
// Port-level checker for the serial character engine.
`timescale 1ns/100ps
module uce_char_engine_monitor (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic cmd_write_in,
    input wire uce_pkg::uce_cmd_t cmd_in,
    input wire logic mode_write_in,
    input wire uce_pkg::uce_mode_t mode_in,
    input wire logic tx_write_in,
    input wire logic [8:0] tx_data_in,
    input wire logic rx_read_in,
    input wire logic sample_tick_in,
    input wire logic serial_clock_in,
    input wire logic rx_line_in,
    input wire logic tx_line_out,
    input wire logic [8:0] rx_data_out,
    input wire uce_pkg::uce_status_t status_out
);
    default clocking mon_cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    sequence s_rx_on;
        cmd_write_in && cmd_in.rx_enable && !cmd_in.rx_disable;
    endsequence
    sequence s_tx_on;
        cmd_write_in && cmd_in.tx_enable && !cmd_in.tx_disable;
    endsequence
    sequence s_clear;
        cmd_write_in && cmd_in.clear_status;
    endsequence
    property p_rx_enable;
        s_rx_on |-> ##2 status_out.rx_enabled;
    endproperty
    property p_tx_enable;
        s_tx_on |-> ##2 status_out.tx_enabled && status_out.tx_holding_free;
    endproperty
    property p_dis_wins;
        cmd_write_in && cmd_in.tx_enable && cmd_in.tx_disable
            && !status_out.tx_enabled |-> ##2 !status_out.tx_enabled;
    endproperty
    property p_off_flags;
        !status_out.tx_enabled |-> !status_out.tx_holding_free
            && !status_out.tx_all_done;
    endproperty
    property p_done_free;
        status_out.tx_all_done |-> status_out.tx_holding_free;
    endproperty
    property p_idle_line;
        status_out.tx_all_done && $past(status_out.tx_all_done) |-> tx_line_out;
    endproperty
    property p_clear;
        s_clear |-> ##2 !status_out.rx_overrun && !status_out.check_bit_error;
    endproperty
    property p_read;
        rx_read_in |-> ##2 !status_out.rx_char_available;
    endproperty
    property p_load;
        $changed(rx_data_out) |-> ##1 status_out.rx_char_available;
    endproperty
    property p_soft;
        cmd_write_in && cmd_in.tx_soft_reset |-> ##3 tx_line_out [*4];
    endproperty
    a_rx_enable: assert property (p_rx_enable)
        else $error("receiver did not enable");
    a_tx_enable: assert property (p_tx_enable)
        else $error("transmitter did not enable");
    a_dis_wins: assert property (p_dis_wins)
        else $error("enable beat disable");
    a_off_flags: assert property (p_off_flags)
        else $error("transmit flags high while disabled");
    a_done_free: assert property (p_done_free)
        else $error("all done without free holding");
    a_idle_line: assert property (p_idle_line)
        else $error("line active while all done");
    a_clear: assert property (p_clear)
        else $error("error flags not cleared");
    a_read: assert property (p_read)
        else $error("read did not clear available");
    a_load: assert property (p_load)
        else $error("holding loaded without available flag");
    a_soft: assert property (p_soft)
        else $error("line not idle after soft reset");
endmodule : uce_char_engine_monitor

bind uce_char_engine uce_char_engine_monitor mon_u (
    .clock_in, .reset_in, .cmd_write_in, .cmd_in, .mode_write_in, .mode_in,
    .tx_write_in, .tx_data_in, .rx_read_in, .sample_tick_in,
    .serial_clock_in, .rx_line_in, .tx_line_out, .rx_data_out, .status_out
);

// ===== uce_remote_model.sv
// Remote serial partner: sends frames and captures the engine's frames.
`timescale 1ns/100ps
module uce_remote_model (
    input wire logic clock_in,
    input wire logic sample_tick_in,
    input wire logic [4:0] os_in,
    input wire logic [3:0] n_bits_in,
    input wire logic tx_line_in,
    output logic rx_line_out,
    output logic [11:0] got_word_out,
    output logic [7:0] got_count_out
);
    task automatic ticks(input int n);
        repeat (n) @(posedge clock_in iff sample_tick_in);
    endtask : ticks

    task automatic send(input logic [11:0] bits, input int n);
        rx_line_out <= 1'h0;
        ticks(os_in);
        for (int i = 0; i < n; i++)
        begin
            rx_line_out <= bits[i];
            ticks(os_in);
        end
        rx_line_out <= 1'h1;
    endtask : send

    // Bits are taken at mid-bit so a small phase slip still reads clean.
    initial
    begin
        rx_line_out = 1'h1;
        got_word_out = 12'h000;
        got_count_out = 8'h00;
        forever
        begin
            @(posedge clock_in iff (sample_tick_in && tx_line_in === 1'h0));
            got_word_out = 12'h000;
            ticks(os_in / 2);
            for (int i = 0; i < n_bits_in; i++)
            begin
                ticks(os_in);
                got_word_out[i] = tx_line_in;
            end
            got_count_out = got_count_out + 8'h01;
        end
    end
endmodule : uce_remote_model

// ===== uce_testbench.sv
// Self-checking bench for the serial character engine.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
    begin \
        n_compared++; \
        if ((gt) !== (ex)) \
        begin \
            fail_count++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
        end \
    end
`define WAITC(cond) \
    for (k = 0; k < 3000 && !(cond); k++) \
        @(negedge clock_in); \
    if (!(cond)) \
    begin \
        fail_count++; \
        $display("[FAIL] wait expected 1 seen 0"); \
        conclude(); \
    end
module testbench;
    typedef struct packed {
        logic [1:0] len;
        logic nine;
        logic [2:0] pm;
        logic msb;
        logic half;
        logic [8:0] data;
        logic par;
    } uce_row_t;
    uce_row_t rows [0:7] = '{
        '{2'h3, 1'h0, 3'h0, 1'h0, 1'h0, 9'h041, 1'h0},
        '{2'h3, 1'h0, 3'h1, 1'h0, 1'h0, 9'h041, 1'h1},
        '{2'h3, 1'h0, 3'h2, 1'h0, 1'h0, 9'h041, 1'h0},
        '{2'h3, 1'h0, 3'h3, 1'h0, 1'h0, 9'h041, 1'h1},
        '{2'h3, 1'h0, 3'h4, 1'h0, 1'h0, 9'h041, 1'h0},
        '{2'h3, 1'h0, 3'h0, 1'h1, 1'h1, 9'h00b, 1'h1},
        '{2'h0, 1'h1, 3'h1, 1'h0, 1'h0, 9'h1f0, 1'h0},
        '{2'h0, 1'h0, 3'h0, 1'h1, 1'h0, 9'h1f3, 1'h1}
    };
    logic clock_in, reset_in, cmd_write, mode_write, tx_write, rx_read;
    logic sample_tick, serial_clock, rx_line, tx_line;
    uce_pkg::uce_cmd_t cmd;
    uce_pkg::uce_mode_t mode;
    uce_pkg::uce_status_t status;
    logic [8:0] tx_data, rx_data, mask;
    logic [4:0] os;
    logic [3:0] n_bits;
    logic [11:0] got_word, frame;
    logic [7:0] got_count, prev;
    uce_row_t r;
    int fail_count, n_compared, k, n;

    uce_char_engine dut_u (
        .clock_in(clock_in), .reset_in(reset_in),
        .cmd_write_in(cmd_write), .cmd_in(cmd),
        .mode_write_in(mode_write), .mode_in(mode),
        .tx_write_in(tx_write), .tx_data_in(tx_data),
        .rx_read_in(rx_read), .sample_tick_in(sample_tick),
        .serial_clock_in(serial_clock), .rx_line_in(rx_line),
        .tx_line_out(tx_line), .rx_data_out(rx_data), .status_out(status)
    );
    uce_remote_model m_u (
        .clock_in(clock_in), .sample_tick_in(sample_tick), .os_in(os),
        .n_bits_in(n_bits), .tx_line_in(tx_line), .rx_line_out(rx_line),
        .got_word_out(got_word), .got_count_out(got_count)
    );

    initial
    begin
        clock_in = 1'h0;
        forever
            #2 clock_in = ~clock_in;
    end
    always @(negedge clock_in)
        sample_tick <= ~sample_tick;

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    // Strobe kinds: 0 command, 1 transmit, 2 read, 3 mode.
    task automatic put(input int w, input logic [8:0] d);
        @(negedge clock_in);
        cmd = d[6:0];
        tx_data = d;
        cmd_write = (w == 0);
        tx_write = (w == 1);
        rx_read = (w == 2);
        mode_write = (w == 3);
        @(negedge clock_in);
        cmd_write = 1'h0;
        tx_write = 1'h0;
        rx_read = 1'h0;
        mode_write = 1'h0;
    endtask : put

    function automatic logic [11:0] build(input uce_row_t x, output int c);
        int nd;
        logic [11:0] f;
        nd = x.nine ? 9 : 5 + x.len;
        f = 12'h000;
        for (int i = 0; i < nd; i++)
            f[i] = x.msb ? x.data[nd - 1 - i] : x.data[i];
        c = nd;
        if (x.pm < 3'h4)
        begin
            f[c] = x.par;
            c++;
        end
        f[c] = 1'h1;
        c++;
        build = f;
    endfunction : build

    initial
    begin
        {cmd_write, mode_write, tx_write, rx_read, sample_tick} = 5'h00;
        {serial_clock, cmd, tx_data, mode} = 28'h0000000;
        {os, n_bits, fail_count, n_compared} = {5'h10, 4'h0, 64'h0};
        reset_in = 1'h1;
        repeat (5) @(negedge clock_in);
        reset_in = 1'h0;
        `CHK("status", 7'h00, status) // Reset state
        `CHK("tx line", 1'h1, tx_line) // Idle level
        put(1, 9'h055);
        put(0, 9'h00c);
        repeat (3) @(negedge clock_in);
        `CHK("tx on", 1'h0, status.tx_enabled) // Disable wins
        put(0, 9'h048);
        repeat (400) @(negedge clock_in);
        `CHK("dropped", 8'h00, got_count) // Write lost
        `CHK("tx flags", 2'h3, status[6:5]) // Empty flags
        foreach (rows[i])
        begin
            r = rows[i];
            mode = {r.len, r.nine, r.pm, r.msb, 3'h0, r.half};
            put(3, 9'h000);
            os = r.half ? 5'h08 : 5'h10;
            frame = build(r, n);
            n_bits = n[3:0];
            mask = r.nine ? 9'h1ff : 9'h1ff >> (4 - r.len);
            prev = got_count;
            fork
                m_u.send(frame, n);
                put(1, r.data);
            join
            `WAITC(got_count != prev)
            `CHK("frame", frame, got_word) // Frame
            `WAITC(status.rx_char_available)
            `CHK("rx data", r.data & mask, rx_data) // Rx
            `CHK("par err", 1'h0, status.check_bit_error) // Rx
            put(2, 9'h000);
            // The next mode write must wait for the stop bit to finish.
            `WAITC(status.tx_all_done)
        end
        mode = 11'h600;
        put(3, 9'h000);
        {os, n_bits} = {5'h10, 4'ha};
        m_u.send(12'h341, 10);
        `WAITC(status.check_bit_error)
        `CHK("overrun", 1'h0, status.rx_overrun) // First char
        m_u.send(12'h242, 10);
        `WAITC(status.rx_overrun)
        `CHK("rx data", 9'h042, rx_data) // Overwrite
        put(0, 9'h001);
        repeat (2) @(negedge clock_in);
        `CHK("errors", 2'h0, status[3:2]) // Cleared
        put(2, 9'h000);
        prev = got_count;
        put(1, 9'h055);
        repeat (2) @(negedge clock_in);
        `WAITC(status.tx_holding_free)
        put(1, 9'h0aa);
        put(0, 9'h004);
        `WAITC(got_count == prev + 8'h02)
        `CHK("frame", 12'h2aa, got_word) // Drain both
        `WAITC(!status.tx_enabled)
        `CHK("tx free", 1'h0, status.tx_holding_free) // Off flags
        fork
            m_u.send(12'h241, 10);
            begin
                // Let the start bit be taken before the disable lands.
                repeat (40) @(negedge clock_in);
                put(0, 9'h020);
            end
        join
        `WAITC(status.rx_char_available)
        `CHK("rx data", 9'h041, rx_data) // Finish char
        `WAITC(!status.rx_enabled)
        put(0, 9'h008);
        put(1, 9'h0ff);
        repeat (100) @(negedge clock_in);
        put(0, 9'h002);
        repeat (4) @(negedge clock_in);
        `CHK("tx line", 1'h1, tx_line) // Stop at once
        `CHK("tx on", 1'h1, status.tx_enabled) // Enable kept
        // Synchronous receive: 5 bits, no parity, two stops, lsb first.
        mode = 11'h08a;
        put(3, 9'h000);
        put(0, 9'h050);
        repeat (2) @(negedge clock_in);
        `CHK("rx flags", 3'h0, status[4:2]) // Rx soft reset
        frame = 12'hfea;
        for (int i = 0; i < 12; i++)
        begin
            if (i == 7)
                `CHK("two stops", 1'h0, status.rx_char_available)
            m_u.rx_line_out <= frame[i];
            repeat (4) @(negedge clock_in);
            serial_clock = 1'h1;
            repeat (4) @(negedge clock_in);
            serial_clock = 1'h0;
        end
        `WAITC(status.rx_char_available)
        `CHK("rx data", 9'h015, rx_data) // Sync receive
        conclude();
    end
endmodule : testbench
